// file: design/fc_cfg_pkg.sv
// Package: register map, field positions and reset values for the port flow control registers
package fc_cfg_pkg;

	// Port count and index of each switch fabric port
	localparam int         NUM_PORTS      = 3;
	localparam logic [1:0] PORT_MII       = 2'h0;
	localparam logic [1:0] PORT_ONE       = 2'h1;
	localparam logic [1:0] PORT_TWO       = 2'h2;

	// Byte offsets of the three flow control registers
	localparam logic [11:0] OFS_PORT1_FC   = 12'h1A0;
	localparam logic [11:0] OFS_PORT2_FC   = 12'h1A4;
	localparam logic [11:0] OFS_PORT0_FC   = 12'h1A8;

	// Field positions inside each register
	localparam int BIT_MANUAL_SEL = 0;
	localparam int BIT_TX_PAUSE   = 1;
	localparam int BIT_RX_PAUSE   = 2;
	localparam int BIT_CUR_TX     = 3;
	localparam int BIT_CUR_RX     = 4;
	localparam int BIT_CUR_DUP    = 5;
	localparam int BIT_BP_EN      = 6;
	localparam int FIELD_WIDTH    = 7;

	// Reset values of bus-side state and of the resolver outputs
	localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;
	localparam logic [2:0]  FLAGS_RESET    = 3'h0;
	localparam logic        OUT_RESET      = 1'h0;

	// AHB-Lite encodings
	localparam int         HTRANS_ACTIVE = 1;
	localparam logic [1:0] HRESP_OKAY    = 2'h0;

	// Map a bus address to a port index, top bit set on a hit
	function automatic logic [2:0] decode_port(input logic [31:0] addr);
		logic [11:0] word;
		word = {addr[11:2], 2'h0};
		if (word == OFS_PORT1_FC) begin
			decode_port = {1'b1, PORT_ONE};
		end else if (word == OFS_PORT2_FC) begin
			decode_port = {1'b1, PORT_TWO};
		end else if (word == OFS_PORT0_FC) begin
			decode_port = {1'b1, PORT_MII};
		end else begin
			decode_port = 3'h0;
		end
	endfunction

endpackage

// file: design/fc_resolve.sv
// Per-port flow control resolution: picks manual or negotiated pause settings and gates by duplex
`timescale 1ns/100ps
module fc_resolve
	import fc_cfg_pkg::*;
(
	// Clock, reset, enable
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	// Software settings
	input  wire logic manual_sel,
	input  wire logic rx_pause_en,
	input  wire logic tx_pause_en,
	input  wire logic backpressure_en,
	// Link state
	input  wire logic autoneg_en,
	input  wire logic duplex_half,
	input  wire logic an_rx_pause,
	input  wire logic an_tx_pause,
	// Settings in effect
	output logic      cur_duplex,
	output logic      cur_rx_pause,
	output logic      cur_tx_pause,
	output logic      backpressure_on
);

	logic cur_duplex_nxt;
	logic cur_rx_nxt;
	logic cur_tx_nxt;
	logic bp_on_nxt;

	// Pick the pause source, then gate pause by full duplex and backpressure by half duplex
	always_comb begin
		cur_duplex_nxt = duplex_half;
		bp_on_nxt      = backpressure_en & duplex_half;
		if (duplex_half) begin
			cur_rx_nxt = 1'b0;
			cur_tx_nxt = 1'b0;
		end else if (manual_sel || !autoneg_en) begin
			cur_rx_nxt = rx_pause_en;
			cur_tx_nxt = tx_pause_en;
		end else begin
			cur_rx_nxt = an_rx_pause;
			cur_tx_nxt = an_tx_pause;
		end
	end

	// Register the settings in effect; reset holds everything off until the link state is seen
	always_ff @(posedge clk) begin
		if (rst) begin
			cur_duplex      <= OUT_RESET;
			cur_rx_pause    <= OUT_RESET;
			cur_tx_pause    <= OUT_RESET;
			backpressure_on <= OUT_RESET;
		end else if (ce) begin
			cur_duplex      <= cur_duplex_nxt;
			cur_rx_pause    <= cur_rx_nxt;
			cur_tx_pause    <= cur_tx_nxt;
			backpressure_on <= bp_on_nxt;
		end
	end

	// Checks on the resolution, one cycle after a clean enabled cycle
	a_pause_fd_only: assert property (@(posedge clk) disable iff (rst)
		($past(ce) && !$past(rst) && $past(duplex_half)) |-> !(cur_rx_pause || cur_tx_pause))
		else $error("pause active in half duplex");
	a_manual_pick: assert property (@(posedge clk) disable iff (rst)
		($past(ce) && !$past(rst) && $past(manual_sel) && !$past(duplex_half))
		|-> (cur_rx_pause == $past(rx_pause_en)) && (cur_tx_pause == $past(tx_pause_en)))
		else $error("manual pause bits not applied");
	a_autoneg_pick: assert property (@(posedge clk) disable iff (rst)
		($past(ce) && !$past(rst) && !$past(manual_sel) && $past(autoneg_en) && !$past(duplex_half))
		|-> (cur_rx_pause == $past(an_rx_pause)) && (cur_tx_pause == $past(an_tx_pause)))
		else $error("negotiated pause not applied");
	a_an_off_pick: assert property (@(posedge clk) disable iff (rst)
		($past(ce) && !$past(rst) && !$past(autoneg_en) && !$past(duplex_half))
		|-> (cur_rx_pause == $past(rx_pause_en)) && (cur_tx_pause == $past(tx_pause_en)))
		else $error("pause bits ignored with negotiation off");
	a_bp_gate: assert property (@(posedge clk) disable iff (rst)
		($past(ce) && !$past(rst)) |-> (backpressure_on == ($past(backpressure_en) && $past(duplex_half))))
		else $error("backpressure gating wrong");
	a_dup_report: assert property (@(posedge clk) disable iff (rst)
		($past(ce) && !$past(rst)) |-> (cur_duplex == $past(duplex_half)))
		else $error("duplex report stale");

endmodule

// file: design/switch_port_flow_control_cfg.sv
// Flow control configuration registers for the three switch ports, AHB-Lite slave
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// Operation
// - One flow control register per switch port, three ports, all bus mapped.
// - Bit 6 read/write enables half-duplex backpressure on the port.
// - Read-only bit 5 shows duplex in effect: 0 full, 1 half.
// - Read-only bit 4 shows whether receive pause is in effect.
// - Read-only bit 3 shows whether transmit pause is in effect.
// - Bit 2 enables pause frame detection under manual select or negotiation off.
// - Bit 1 enables pause frame generation under manual select or negotiation off.
// - Select clear with negotiation on uses negotiated result; otherwise the enable bits.
// - Select set applies manual pause enables whenever the port runs full duplex.
// - Fields load from straps at reset and reload when the loader rewrites straps.
// - Writes here never alter the PHY advertisement flow control fields.
// - Reads return flow control settings in effect, manual or negotiated.
// - Bits 31 to 7 are reserved, read-only, read as zero.
module switch_port_flow_control_cfg
	import fc_cfg_pkg::*;
(
	// Clock, reset, clock enable
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        CE,
	// AHB-Lite slave
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic      [1:0]  HRESP,
	// Configuration straps, indexed by port number
	input  wire logic [2:0]  BACKPRESSURE_STRAP,
	input  wire logic [2:0]  FD_PAUSE_STRAP,
	input  wire logic [2:0]  MANUAL_SELECT_STRAP,
	input  wire logic        STRAP_RELOAD,
	// Link state from the port MACs and PHYs
	input  wire logic [2:0]  AUTONEG_EN,
	input  wire logic [2:0]  DUPLEX_HALF,
	input  wire logic [2:0]  AN_RX_PAUSE,
	input  wire logic [2:0]  AN_TX_PAUSE,
	// Flow control in effect, to the switch fabric
	output logic      [2:0]  BACKPRESSURE_ON,
	output logic      [2:0]  RX_PAUSE_ON,
	output logic      [2:0]  TX_PAUSE_ON
);

	// Software-visible fields, one bit per port
	logic [2:0]  manual_r;
	logic [2:0]  manual_nxt;
	logic [2:0]  rx_en_r;
	logic [2:0]  rx_en_nxt;
	logic [2:0]  tx_en_r;
	logic [2:0]  tx_en_nxt;
	logic [2:0]  bp_en_r;
	logic [2:0]  bp_en_nxt;
	// Bus data phase state
	logic        wr_pend_r;
	logic        wr_pend_nxt;
	logic [1:0]  wr_port_r;
	logic [1:0]  wr_port_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	// Settings in effect, from the resolvers
	logic [2:0]  cur_dup;
	logic [2:0]  cur_rx;
	logic [2:0]  cur_tx;
	// Address phase decode
	logic        addr_taken;
	logic [2:0]  dec;

	// Address phase is taken only while enabled, since HREADYOUT follows CE
	assign addr_taken = HSEL && HREADY && HTRANS[HTRANS_ACTIVE] && CE;
	assign dec        = decode_port(HADDR);

	// Bus answers: zero wait states, stalled while frozen, always OKAY
	assign HREADYOUT = CE;
	assign HRESP     = HRESP_OKAY;
	assign HRDATA    = rdata_r;

	// Fields, write data phase, strap reload and read capture
	always_comb begin
		manual_nxt  = manual_r;
		rx_en_nxt   = rx_en_r;
		tx_en_nxt   = tx_en_r;
		bp_en_nxt   = bp_en_r;
		wr_pend_nxt = 1'b0;
		wr_port_nxt = wr_port_r;
		rdata_nxt   = rdata_r;
		if (RST) begin
			manual_nxt  = MANUAL_SELECT_STRAP;
			rx_en_nxt   = FD_PAUSE_STRAP;
			tx_en_nxt   = FD_PAUSE_STRAP;
			bp_en_nxt   = BACKPRESSURE_STRAP;
			wr_port_nxt = PORT_MII;
			rdata_nxt   = RDATA_RESET;
		end else begin
			// Write data stands in the cycle after the address phase
			if (wr_pend_r) begin
				manual_nxt[wr_port_r] = HWDATA[BIT_MANUAL_SEL];
				tx_en_nxt[wr_port_r]  = HWDATA[BIT_TX_PAUSE];
				rx_en_nxt[wr_port_r]  = HWDATA[BIT_RX_PAUSE];
				bp_en_nxt[wr_port_r]  = HWDATA[BIT_BP_EN];
			end
			// Loader rewrite wins over a software write in the same cycle
			if (STRAP_RELOAD) begin
				manual_nxt = MANUAL_SELECT_STRAP;
				rx_en_nxt  = FD_PAUSE_STRAP;
				tx_en_nxt  = FD_PAUSE_STRAP;
				bp_en_nxt  = BACKPRESSURE_STRAP;
			end
			if (addr_taken) begin
				wr_pend_nxt = HWRITE && dec[2];
				wr_port_nxt = dec[1:0];
				// Read from next values so a write just before is seen back to back
				if (!HWRITE) begin
					rdata_nxt = RDATA_RESET;
					if (dec[2]) begin
						rdata_nxt[BIT_MANUAL_SEL] = manual_nxt[dec[1:0]];
						rdata_nxt[BIT_TX_PAUSE]   = tx_en_nxt[dec[1:0]];
						rdata_nxt[BIT_RX_PAUSE]   = rx_en_nxt[dec[1:0]];
						rdata_nxt[BIT_CUR_TX]     = cur_tx[dec[1:0]];
						rdata_nxt[BIT_CUR_RX]     = cur_rx[dec[1:0]];
						rdata_nxt[BIT_CUR_DUP]    = cur_dup[dec[1:0]];
						rdata_nxt[BIT_BP_EN]      = bp_en_nxt[dec[1:0]];
					end
				end
			end
		end
	end

	// Register stage; reset acts even while frozen so straps are always caught
	always_ff @(posedge CLK) begin
		if (RST || CE) begin
			manual_r  <= manual_nxt;
			rx_en_r   <= rx_en_nxt;
			tx_en_r   <= tx_en_nxt;
			bp_en_r   <= bp_en_nxt;
			wr_pend_r <= wr_pend_nxt;
			wr_port_r <= wr_port_nxt;
			rdata_r   <= rdata_nxt;
		end
	end

	// One resolver per port; nothing here drives the PHY advertisement, so it stays untouched
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
			fc_resolve u_resolve (
				.clk             (CLK),
				.rst             (RST),
				.ce              (CE),
				.manual_sel      (manual_r[gp]),
				.rx_pause_en     (rx_en_r[gp]),
				.tx_pause_en     (tx_en_r[gp]),
				.backpressure_en (bp_en_r[gp]),
				.autoneg_en      (AUTONEG_EN[gp]),
				.duplex_half     (DUPLEX_HALF[gp]),
				.an_rx_pause     (AN_RX_PAUSE[gp]),
				.an_tx_pause     (AN_TX_PAUSE[gp]),
				.cur_duplex      (cur_dup[gp]),
				.cur_rx_pause    (cur_rx[gp]),
				.cur_tx_pause    (cur_tx[gp]),
				.backpressure_on (BACKPRESSURE_ON[gp])
			);
		end
	endgenerate

	// Settings in effect go straight to the fabric
	assign RX_PAUSE_ON = cur_rx;
	assign TX_PAUSE_ON = cur_tx;

	// Checks on the register file
	a_reserved_zero: assert property (@(posedge CLK) disable iff (RST)
		HRDATA[31:FIELD_WIDTH] == 25'h0)
		else $error("reserved read bits not zero");
	a_write_stores: assert property (@(posedge CLK) disable iff (RST)
		(wr_pend_r && CE && !STRAP_RELOAD) |=> (bp_en_r[$past(wr_port_r)] == $past(HWDATA[BIT_BP_EN]))
		&& (manual_r[$past(wr_port_r)] == $past(HWDATA[BIT_MANUAL_SEL])))
		else $error("written field not stored");
	a_strap_reload: assert property (@(posedge CLK) disable iff (RST)
		(STRAP_RELOAD && CE) |=> (manual_r == $past(MANUAL_SELECT_STRAP))
		&& (rx_en_r == $past(FD_PAUSE_STRAP)) && (bp_en_r == $past(BACKPRESSURE_STRAP)))
		else $error("strap reload not applied");
	a_read_live: assert property (@(posedge CLK) disable iff (RST)
		(addr_taken && !HWRITE && dec[2]) |=> (HRDATA[BIT_CUR_RX] == $past(cur_rx[dec[1:0]]))
		&& (HRDATA[BIT_CUR_TX] == $past(cur_tx[dec[1:0]])))
		else $error("read misses settings in effect");
	a_unmapped_zero: assert property (@(posedge CLK) disable iff (RST)
		(addr_taken && !HWRITE && !dec[2]) |=> (HRDATA == RDATA_RESET) && !wr_pend_r)
		else $error("unmapped read not zero");

endmodule

// file: testbench/tb_switch_port_flow_control_cfg.sv
// Self-checking bench for the port flow control register bank over AHB-Lite
`timescale 1ns/100ps
module tb_switch_port_flow_control_cfg
	import fc_cfg_pkg::*;
;
	// Clock, reset and bus master state
	logic        clk       = 1'b0;
	logic        rst       = 1'b1;
	logic        ce        = 1'b1;
	logic        hsel      = 1'b0;
	logic        hwrite    = 1'b0;
	logic [1:0]  htrans    = 2'h0;
	logic [31:0] haddr     = 32'h0;
	logic [31:0] hwdata    = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic [1:0]  hresp;
	// Straps, link state and outputs in effect
	logic [2:0]  bp_strap  = 3'h2;
	logic [2:0]  fd_strap  = 3'h3;
	logic [2:0]  man_strap = 3'h6;
	logic        reload    = 1'b0;
	logic [2:0]  an_en     = 3'h5;
	logic [2:0]  dup_half  = 3'h4;
	logic [2:0]  an_rx     = 3'h1;
	logic [2:0]  an_tx     = 3'h5;
	logic [2:0]  bp_on;
	logic [2:0]  rx_on;
	logic [2:0]  tx_on;
	// Bench copy of the writable fields
	logic [2:0]  m_bp;
	logic [2:0]  m_rx;
	logic [2:0]  m_tx;
	logic [2:0]  m_man;
	int          miscompares = 0;
	int          tests_run   = 0;
	int          cycles      = 0;

	always #10 clk = ~clk;

	switch_port_flow_control_cfg switch_port_flow_control_cfg_inst (
		.CLK(clk), .RST(rst), .CE(ce), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .BACKPRESSURE_STRAP(bp_strap), .FD_PAUSE_STRAP(fd_strap),
		.MANUAL_SELECT_STRAP(man_strap), .STRAP_RELOAD(reload), .AUTONEG_EN(an_en),
		.DUPLEX_HALF(dup_half), .AN_RX_PAUSE(an_rx), .AN_TX_PAUSE(an_tx),
		.BACKPRESSURE_ON(bp_on), .RX_PAUSE_ON(rx_on), .TX_PAUSE_ON(tx_on));

	// Hang guard, well above the roughly 1100 cycles the sequence needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			miscompares = miscompares + 1;
			close_out();
		end
	end

	task automatic close_out();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One single transfer; entered just after a rising edge, waits on hready
	task automatic bus(input logic [31:0] addr, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= addr;
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask

	function automatic logic [31:0] adr(input int p);
		adr = {20'h0, (p == 0) ? OFS_PORT0_FC : (p == 1) ? OFS_PORT1_FC : OFS_PORT2_FC};
	endfunction

	// Value in effect: manual bits unless negotiation decides; pause only in full duplex
	function automatic logic [31:0] expv(input int p);
		logic sel;
		logic rxc;
		logic txc;
		sel = m_man[p] | ~an_en[p];
		rxc = ~dup_half[p] & (sel ? m_rx[p] : an_rx[p]);
		txc = ~dup_half[p] & (sel ? m_tx[p] : an_tx[p]);
		expv = {25'h0, m_bp[p], dup_half[p], rxc, txc, m_rx[p], m_tx[p], m_man[p]};
	endfunction

	task automatic load_model();
		m_bp = bp_strap;
		m_rx = fd_strap;
		m_tx = fd_strap;
		m_man = man_strap;
	endtask

	task automatic chk(input int p);
		logic [31:0] rd;
		logic [31:0] e;
		e = expv(p);
		bus(adr(p), 1'b0, 32'h0, rd);
		cmp(rd, e);
		cmp({29'h0, bp_on[p], rx_on[p], tx_on[p]}, {29'h0, e[6] & e[5], e[4], e[3]});
	endtask

	task automatic chk_all();
		for (int p = 0; p < NUM_PORTS; p++) begin
			chk(p);
		end
	endtask

	// Main sequence
	initial begin
		logic [31:0] rd;
		logic [31:0] wd;
		logic [6:0]  k;
		int          p;
		load_model();
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		chk_all();
		// Every field value against every duplex and negotiation setting, ports in turn; reserved and RO bits written as ones
		for (int i = 0; i < 128; i++) begin
			k = i[6:0];
			p = i % 3;
			dup_half[p] <= k[4];
			an_en[p] <= k[5];
			an_rx[p] <= k[6] ^ k[0];
			an_tx[p] <= k[6] ^ k[1];
			wd = {25'h1FFFFFF, k[3], 3'h7, k[2:0]};
			bus(adr(p), 1'b1, wd, rd);
			m_bp[p] = k[3];
			m_rx[p] = k[2];
			m_tx[p] = k[1];
			m_man[p] = k[0];
			bus(adr(p), 1'b0, 32'h0, rd);
			cmp(rd & 32'h0000_0047, {25'h0, k[3], 3'h0, k[2:0]});
			repeat (2) @(posedge clk);
			chk(p);
		end
		// Unmapped places: writes dropped, reads zero
		bus(32'h0000_01AC, 1'b1, 32'hFFFF_FFFF, rd);
		bus(32'h0000_01AC, 1'b0, 32'h0, rd);
		cmp(rd, 32'h0);
		bus(32'h0000_019C, 1'b0, 32'h0, rd);
		cmp(rd, 32'h0);
		chk_all();
		// Loader rewrites the straps; fields follow
		bp_strap <= 3'h5;
		fd_strap <= 3'h4;
		man_strap <= 3'h3;
		reload <= 1'b1;
		@(posedge clk);
		reload <= 1'b0;
		load_model();
		repeat (3) @(posedge clk);
		chk_all();
		// Second reset in mid-run with other straps
		bp_strap <= 3'h3;
		fd_strap <= 3'h6;
		man_strap <= 3'h1;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		load_model();
		repeat (3) @(posedge clk);
		chk_all();
		// Freeze: bus stalls, answers OKAY, outputs hold while link state moves
		wd = {23'h0, bp_on, rx_on, tx_on};
		ce <= 1'b0;
		dup_half <= ~dup_half;
		repeat (3) @(posedge clk);
		cmp({29'h0, hreadyout, hresp}, 32'h0);
		cmp({23'h0, bp_on, rx_on, tx_on}, wd);
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		chk_all();
		close_out();
	end
endmodule
